// ===== shared/brc_pkg.sv
// Constants, types and register map for the brownout reset control block.
// Assumes an AHB-Lite slave port with 32-bit data and a 25 MHz core clock.
// Summary of operation
// (RQ1) Level codes 66,55,33,99,aa pick thresholds; f0 turns the monitor off.
// (RQ2) Any other level code resets the chip and restores the level register.
// (RQ3) That bad-code reset fires only after the soft reset delay.
// (RQ4) Low supply resets only when it persists beyond the filter time.
// (RQ5) A genuine low-supply reset keeps the level register contents.
// (RQ6) Filter codes 0..3 need about 8, 32, 64 or 128 slow periods.
// (RQ7) Upper six filter register bits read as zero.
// (RQ8) Low-supply reset sets the brownout event flag; only software zero clears it.
// (RQ9) Bad level code reset sets its flag; only software zero clears it.
// (RQ10) Watchdog expiry in fast or slow mode resets and sets the expiry flag.
// (RQ11) Expiry in sleep or idle clears only pc and sp, sets both flags.
// (RQ12) Power-on clears expiry and power-down flags; brownout leaves them.
// (RQ13) Power-on zeroes pc, masks interrupts, restarts watchdog, stops timer, inputs, stack top.
// (RQ14) Normal expiry reloads level, filter, watchdog control; sleep expiry keeps them.
// (RQ15) Illegal watchdog enable code reset sets the misuse flag; software clears it.
// (RQ16) The brownout monitor is disabled during sleep or idle.
// (RQ17) Low-supply input is synchronised; filter counts slow cycles, restarts on release.
package brc_pkg;
    // Register byte offsets
    localparam logic [7:0] BRC_LEVEL_OFS = 8'h00;
    localparam logic [7:0] BRC_FILTER_OFS = 8'h04;
    localparam logic [7:0] BRC_CAUSE_OFS = 8'h08;
    localparam logic [7:0] BRC_WDCTL_OFS = 8'h0c;
    localparam logic [7:0] BRC_STATUS_OFS = 8'h10;
    // Reset values
    localparam logic [7:0] BRC_LEVEL_POR = 8'h66;
    localparam logic [1:0] BRC_FILTER_POR = 2'h1;
    localparam logic [7:0] BRC_WDCTL_POR = 8'h57;
    // Level codes
    localparam logic [7:0] BRC_LV_1V70 = 8'h66;
    localparam logic [7:0] BRC_LV_2V20 = 8'h55;
    localparam logic [7:0] BRC_LV_2V55 = 8'h33;
    localparam logic [7:0] BRC_LV_3V15 = 8'h99;
    localparam logic [7:0] BRC_LV_3V80 = 8'haa;
    localparam logic [7:0] BRC_LV_OFF = 8'hf0;
    // Watchdog enable codes in bits 7..3
    localparam logic [4:0] BRC_WE_ON = 5'h0a;
    localparam logic [4:0] BRC_WE_OFF = 5'h15;
    // Cause flag bit positions
    localparam int BRC_CF_WRF = 0;
    localparam int BRC_CF_LRF = 1;
    localparam int BRC_CF_LVF = 2;
    // Status bit positions
    localparam int BRC_ST_PDF = 0;
    localparam int BRC_ST_TO = 1;
    // Filter thresholds in slow periods, per select code
    localparam logic [7:0] BRC_FILT_0 = 8'h08;
    localparam logic [7:0] BRC_FILT_1 = 8'h20;
    localparam logic [7:0] BRC_FILT_2 = 8'h40;
    localparam logic [7:0] BRC_FILT_3 = 8'h80;
    // Soft reset delay
    localparam int BRC_CLK_MHZ = 25;
    localparam int BRC_SRESET_US = 1;
    localparam logic [7:0] BRC_SRESET_CYC = 8'(BRC_SRESET_US * BRC_CLK_MHZ);
    // Reset source encoding
    typedef enum logic [3:0] {
        BRC_RS_NONE = 4'h0,
        BRC_RS_BOD = 4'h1,
        BRC_RS_BADLV = 4'h2,
        BRC_RS_WDNORM = 4'h4,
        BRC_RS_WDCTL = 4'h8
    } brc_src_t;
    // Reset request bundle to the core
    typedef struct packed {
        logic chip_rst;
        logic pc_sp_clr;
    } brc_rst_t;
endpackage

// ===== design/brc_filter.sv
// Persistence filter for the synchronised low-supply indication.
// Assumes slow_tick pulses once per slow oscillator period.
`timescale 1ns/1ns
module brc_filter
    import brc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Control
    input wire logic low_sync,
    input wire logic slow_tick,
    input wire logic [1:0] brownout_filter_select,
    // Result
    output logic trip
);
    // ==========================================
    // Count slow periods while low is held
    logic [7:0] cnt_ff, nxt_cnt;
    logic [7:0] limit;
    always_comb begin
        unique case (brownout_filter_select)
            2'h0: limit = BRC_FILT_0; // RQ6
            2'h1: limit = BRC_FILT_1;
            2'h2: limit = BRC_FILT_2;
            default: limit = BRC_FILT_3;
        endcase
        nxt_cnt = cnt_ff;
        if (!low_sync) begin
            nxt_cnt = 8'h00; // RQ17
        end else if (slow_tick && cnt_ff < limit) begin
            nxt_cnt = cnt_ff + 8'h01;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    // Tick phase is unknown at onset, so the window is limit-1 to limit periods
    // Compare with >= so a smaller select written mid-count trips at once; the count holds, so == would never trip
    assign trip = low_sync && cnt_ff >= limit; // RQ4
    a_filter_clear: assert property (@(posedge core_clk) disable iff (srst)
        !low_sync |=> cnt_ff == 8'h00) else $error("filter did not restart"); // RQ17
    a_filter_trip: assert property (@(posedge core_clk) disable iff (srst) // RQ4
        $rose(trip) |-> $past(low_sync) && cnt_ff >= BRC_FILT_0) else $error("early trip");
endmodule

// ===== design/brc_top.sv
// Brownout reset control: level/filter decode, reset causes, status flags.
// Assumes a single AHB-Lite master; core mode and watchdog events are inputs.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module brc_top
    import brc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Supply, mode and watchdog
    input wire logic low_supply,
    input wire logic slow_tick,
    input wire logic sleep_mode,
    input wire logic wdt_expire,
    // Reset, watchdog control and threshold outputs
    output logic chip_rst,
    output logic pc_sp_clr,
    output logic wdt_enable,
    output logic [2:0] wdt_period_sel,
    output logic [2:0] brownout_threshold
);
    // ==========================================
    // Bus address phase capture
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] addr_ff, nxt_addr;
    logic rd_take;
    always_comb begin
        rd_take = hsel && hready && htrans[1] && !hwrite;
        nxt_wr_pend = hsel && hready && htrans[1] && hwrite;
        nxt_addr = addr_ff;
        if (hsel && hready && htrans[1]) begin
            nxt_addr = haddr[7:0];
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            addr_ff <= nxt_addr;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================
    // Low supply synchroniser and filter
    logic low_s1_ff, low_s2_ff, trip;
    logic mon_on;
    logic [7:0] brownout_level_code_ff;
    logic [1:0] brownout_filter_select_ff;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            low_s1_ff <= 1'b0;
            low_s2_ff <= 1'b0;
        end else begin
            low_s1_ff <= low_supply;
            low_s2_ff <= low_s1_ff;
        end
    end
    // Monitor idles in sleep and when switched off
    assign mon_on = !sleep_mode && brownout_level_code_ff != BRC_LV_OFF; // RQ16
    brc_filter u_filter (
        .core_clk(core_clk),
        .srst(srst),
        .low_sync(low_s2_ff && mon_on),
        .slow_tick(slow_tick),
        .brownout_filter_select(brownout_filter_select_ff),
        .trip(trip)
    );

    // ==========================================
    // Level decode
    logic lv_valid;
    always_comb begin
        lv_valid = 1'b1;
        brownout_threshold = 3'h0;
        unique case (brownout_level_code_ff) // RQ1
            BRC_LV_1V70: brownout_threshold = 3'h1;
            BRC_LV_2V20: brownout_threshold = 3'h2;
            BRC_LV_2V55: brownout_threshold = 3'h3;
            BRC_LV_3V15: brownout_threshold = 3'h4;
            BRC_LV_3V80: brownout_threshold = 3'h5;
            BRC_LV_OFF: brownout_threshold = 3'h0;
            default: lv_valid = 1'b0;
        endcase
    end

    // ==========================================
    // Reset sequencer
    typedef enum logic [3:0] {
        BRC_S_RUN = 4'b0001,
        BRC_S_DLY_LV = 4'b0010,
        BRC_S_DLY_WD = 4'b0100,
        BRC_S_RST = 4'b1000
    } brc_state_t;
    brc_state_t st_ff, nxt_st;
    logic [7:0] dly_ff, nxt_dly;
    brc_src_t src_ff, nxt_src;
    logic [7:0] wdctl_ff;
    logic we_valid;
    assign we_valid = wdctl_ff[7:3] == BRC_WE_ON || wdctl_ff[7:3] == BRC_WE_OFF;
    always_comb begin
        nxt_st = st_ff;
        nxt_dly = dly_ff;
        nxt_src = BRC_RS_NONE;
        unique case (st_ff)
            BRC_S_RUN: begin
                nxt_dly = 8'h00;
                if (trip) begin
                    nxt_st = BRC_S_RST;
                    nxt_src = BRC_RS_BOD; // RQ4
                end else if (wdt_expire && !sleep_mode) begin
                    nxt_st = BRC_S_RST;
                    nxt_src = BRC_RS_WDNORM; // RQ10
                end else if (!lv_valid) begin
                    nxt_st = BRC_S_DLY_LV; // RQ3
                end else if (!we_valid) begin
                    nxt_st = BRC_S_DLY_WD;
                end
            end
            BRC_S_DLY_LV, BRC_S_DLY_WD: begin
                nxt_dly = dly_ff + 8'h01;
                if (dly_ff == BRC_SRESET_CYC - 8'h01) begin
                    nxt_st = BRC_S_RST;
                    nxt_src = (st_ff == BRC_S_DLY_LV) ? BRC_RS_BADLV : BRC_RS_WDCTL; // RQ3
                end
            end
            BRC_S_RST: begin
                nxt_st = BRC_S_RUN;
            end
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_ff <= BRC_S_RUN;
            dly_ff <= 8'h00;
            src_ff <= BRC_RS_NONE;
        end else begin
            st_ff <= nxt_st;
            dly_ff <= nxt_dly;
            src_ff <= nxt_src;
        end
    end
    // One-cycle reset pulse in the same cycle that src_ff holds the latched cause
    logic wd_sleep_ff;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wd_sleep_ff <= 1'b0;
        end else begin
            wd_sleep_ff <= st_ff == BRC_S_RUN && wdt_expire && sleep_mode && !trip;
        end
    end
    brc_rst_t rst_out;
    // Power-on (srst) also drives chip reset so the core does its full init
    assign rst_out.chip_rst = srst || st_ff == BRC_S_RST; // RQ13
    assign rst_out.pc_sp_clr = wd_sleep_ff; // RQ11
    assign chip_rst = rst_out.chip_rst;
    assign pc_sp_clr = rst_out.pc_sp_clr;

    // ==========================================
    // Registers
    logic [7:0] nxt_level, nxt_wdctl;
    logic [1:0] nxt_filter;
    logic [2:0] cause_ff, nxt_cause;
    logic [1:0] stat_ff, nxt_stat;
    logic wr_lv, wr_flt, wr_cause, wr_wd;
    always_comb begin
        wr_lv = wr_pend_ff && addr_ff == BRC_LEVEL_OFS;
        wr_flt = wr_pend_ff && addr_ff == BRC_FILTER_OFS;
        wr_cause = wr_pend_ff && addr_ff == BRC_CAUSE_OFS;
        wr_wd = wr_pend_ff && addr_ff == BRC_WDCTL_OFS;
        nxt_level = wr_lv ? hwdata[7:0] : brownout_level_code_ff;
        nxt_filter = wr_flt ? hwdata[1:0] : brownout_filter_select_ff;
        nxt_wdctl = wr_wd ? hwdata[7:0] : wdctl_ff;
        nxt_cause = cause_ff;
        nxt_stat = stat_ff;
        // Software may only clear flags; write of one is ignored
        if (wr_cause) begin
            nxt_cause = cause_ff & hwdata[2:0]; // RQ8 RQ9 RQ15
        end
        if (src_ff == BRC_RS_BADLV) begin
            nxt_level = BRC_LEVEL_POR; // RQ2
        end
        if (src_ff == BRC_RS_WDNORM) begin
            nxt_level = BRC_LEVEL_POR; // RQ14
            nxt_filter = BRC_FILTER_POR;
            nxt_wdctl = BRC_WDCTL_POR;
        end
        // Set wins over a same-cycle software clear
        if (src_ff == BRC_RS_BOD) begin
            nxt_cause[BRC_CF_LVF] = 1'b1; // RQ8 RQ5
        end
        if (src_ff == BRC_RS_BADLV) begin
            nxt_cause[BRC_CF_LRF] = 1'b1; // RQ9
        end
        if (src_ff == BRC_RS_WDCTL) begin
            nxt_cause[BRC_CF_WRF] = 1'b1; // RQ15
        end
        if (src_ff == BRC_RS_WDNORM) begin
            nxt_stat[BRC_ST_TO] = 1'b1; // RQ10 RQ12
        end
        if (wd_sleep_ff) begin
            nxt_stat = 2'h3; // RQ11
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            brownout_level_code_ff <= BRC_LEVEL_POR;
            brownout_filter_select_ff <= BRC_FILTER_POR;
            wdctl_ff <= BRC_WDCTL_POR;
            cause_ff <= 3'h0;
            stat_ff <= 2'h0; // RQ12
        end else begin
            brownout_level_code_ff <= nxt_level;
            brownout_filter_select_ff <= nxt_filter;
            wdctl_ff <= nxt_wdctl;
            cause_ff <= nxt_cause;
            stat_ff <= nxt_stat;
        end
    end
    assign wdt_enable = wdctl_ff[7:3] == BRC_WE_ON;
    assign wdt_period_sel = wdctl_ff[2:0];

    // ==========================================
    // Read data, registered in the data phase
    logic [31:0] rdata_ff, nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (rd_take) begin
            unique case (haddr[7:0])
                BRC_LEVEL_OFS: nxt_rdata = {24'h000000, brownout_level_code_ff};
                BRC_FILTER_OFS: nxt_rdata = {30'h0, brownout_filter_select_ff}; // RQ7
                BRC_CAUSE_OFS: nxt_rdata = {29'h0, cause_ff};
                BRC_WDCTL_OFS: nxt_rdata = {24'h000000, wdctl_ff};
                BRC_STATUS_OFS: nxt_rdata = {30'h0, stat_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign hrdata = rdata_ff;

    // ==========================================
    // Checks
    a_badlv_delay: assert property (@(posedge core_clk) disable iff (srst)
        st_ff == BRC_S_RUN && !lv_valid && !trip && !(wdt_expire && !sleep_mode)
        |=> !chip_rst [*8]) else $error("bad level reset too early"); // RQ3
    a_badlv_flag: assert property (@(posedge core_clk) disable iff (srst)
        src_ff == BRC_RS_BADLV |=> cause_ff[BRC_CF_LRF]
        && brownout_level_code_ff == BRC_LEVEL_POR) else $error("bad level not handled"); // RQ2
    a_bod_keep: assert property (@(posedge core_clk) disable iff (srst)
        src_ff == BRC_RS_BOD && !wr_lv |=> cause_ff[BRC_CF_LVF]
        && $stable(brownout_level_code_ff)) else $error("brownout flag or level wrong"); // RQ5
    a_bod_stat: assert property (@(posedge core_clk) disable iff (srst)
        src_ff == BRC_RS_BOD && !wd_sleep_ff |=> $stable(stat_ff))
        else $error("brownout touched status"); // RQ12
    a_wd_norm: assert property (@(posedge core_clk) disable iff (srst)
        src_ff == BRC_RS_WDNORM |=> stat_ff[BRC_ST_TO] && wdctl_ff == BRC_WDCTL_POR
        && brownout_filter_select_ff == BRC_FILTER_POR) else $error("watchdog reload"); // RQ14
    a_wd_sleep: assert property (@(posedge core_clk) disable iff (srst)
        pc_sp_clr |=> stat_ff == 2'h3 && !chip_rst) else $error("sleep expiry"); // RQ11
    a_flag_hold: assert property (@(posedge core_clk) disable iff (srst)
        cause_ff[BRC_CF_LVF] && !wr_cause |=> cause_ff[BRC_CF_LVF])
        else $error("flag cleared by hardware"); // RQ8
    a_sleep_mon: assert property (@(posedge core_clk) disable iff (srst)
        sleep_mode [*3] |-> !trip) else $error("monitor active in sleep"); // RQ16
    a_wdctl_flag: assert property (@(posedge core_clk) disable iff (srst)
        src_ff == BRC_RS_WDCTL |=> cause_ff[BRC_CF_WRF]) else $error("misuse flag"); // RQ15

    // Reset pulse shape, software clears, read-as-zero bits, sleep expiry and power-on reset
    a_rst_pulse: assert property (@(posedge core_clk) disable iff (srst) // RQ4
        st_ff == BRC_S_RUN && trip |=> chip_rst ##1 !chip_rst)
        else $error("brownout reset pulse wrong");
    a_sw_clear: assert property (@(posedge core_clk) disable iff (srst) // RQ9
        wr_cause && !hwdata[BRC_CF_LRF] && src_ff != BRC_RS_BADLV |=> !cause_ff[BRC_CF_LRF])
        else $error("bad level flag not cleared");
    a_wrf_clear: assert property (@(posedge core_clk) disable iff (srst) // RQ15
        wr_cause && !hwdata[BRC_CF_WRF] && src_ff != BRC_RS_WDCTL |=> !cause_ff[BRC_CF_WRF])
        else $error("misuse flag not cleared");
    a_filter_rd: assert property (@(posedge core_clk) disable iff (srst) // RQ7
        rd_take && haddr[7:0] == BRC_FILTER_OFS |=> hrdata[31:2] == 30'h0)
        else $error("filter upper bits not zero");
    a_sleep_rst: assert property (@(posedge core_clk) disable iff (srst) // RQ11
        st_ff == BRC_S_RUN && wdt_expire && sleep_mode && !trip |=> !chip_rst)
        else $error("sleep expiry reset the chip");
    a_por_rst: assert property (@(posedge core_clk) // RQ13
        srst |-> chip_rst) else $error("no chip reset during power-on");
endmodule

// ===== dv/brownout_reset_control_tb.sv
// Self-checking testbench for the brownout reset control block.
// Assumes brc_top as the device, AHB-Lite with zero-wait slave, 25 MHz core clock.
`timescale 1ns/1ns
module brownout_reset_control_tb;
    import brc_pkg::*;
    // ==============================================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic low_supply = 1'b0;
    logic slow_tick = 1'b0;
    logic sleep_mode = 1'b0;
    logic wdt_expire = 1'b0;
    logic [1:0] tick_div = 2'h0;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic chip_rst;
    wire logic pc_sp_clr;
    wire logic wdt_enable;
    wire logic [2:0] wdt_period_sel;
    wire logic [2:0] brownout_threshold;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    brc_top dut (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .low_supply(low_supply),
        .slow_tick(slow_tick), .sleep_mode(sleep_mode), .wdt_expire(wdt_expire),
        .chip_rst(chip_rst), .pc_sp_clr(pc_sp_clr), .wdt_enable(wdt_enable),
        .wdt_period_sel(wdt_period_sel), .brownout_threshold(brownout_threshold));
    assign hready = hreadyout;
    always #20 core_clk = ~core_clk;
    // ==============================================================
    // Slow oscillator stand-in: one tick every four core cycles keeps runs short
    always @(posedge core_clk) begin
        tick_div <= tick_div + 2'h1;
        slow_tick <= (tick_div == 2'h3);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("mismatch at %0t: run did not finish in time", $time);
            tally_and_finish();
        end
    end
    // ==============================================================
    // Shared tasks
    task automatic tally_and_finish();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, {24'h0, exp}, what);
    endtask
    // Counts edges and slow ticks until a whole-chip reset pulse or the limit
    task automatic wait_rst(input int lim, output int n, output int nt);
        n = 0;
        nt = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (slow_tick === 1'b1) nt++;
        end while (chip_rst !== 1'b1 && n < lim);
    endtask
    task automatic pulse_expire();
        wdt_expire <= 1'b1;
        @(posedge core_clk);
        wdt_expire <= 1'b0;
    endtask
    // ==============================================================
    // Scenarios
    task automatic t_power_on();
        check({29'h0, brownout_threshold}, 32'h1, "threshold after power-on");
        check({31'h0, wdt_enable}, 32'h1, "watchdog enable after power-on");
        check({31'h0, hresp}, 32'h0, "bus response okay");
        rd(BRC_LEVEL_OFS, 8'h66, "level reset value");
        rd(BRC_FILTER_OFS, 8'h01, "filter reset value");
        rd(BRC_WDCTL_OFS, 8'h57, "watchdog ctrl reset value");
        rd(BRC_CAUSE_OFS, 8'h00, "cause flags reset value");
        rd(BRC_STATUS_OFS, 8'h00, "status after power-on");
        rd(8'h20, 8'h00, "unmapped address");
    endtask
    task automatic t_level_decode();
        logic [7:0] codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};
        logic [2:0] sel [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
        for (int i = 0; i < 6; i++) begin
            wr(BRC_LEVEL_OFS, codes[i]);
            @(posedge core_clk);
            check({29'h0, brownout_threshold}, {29'h0, sel[i]}, "threshold decode");
            rd(BRC_LEVEL_OFS, codes[i], "level readback");
        end
        wr(BRC_FILTER_OFS, 8'hff);
        rd(BRC_FILTER_OFS, 8'h03, "filter upper bits");
    endtask
    // Held low supply must trip after the selected number of slow periods
    task automatic t_filter_lengths();
        int n;
        int nt;
        int want [4] = '{8, 32, 64, 128};
        for (int s = 0; s < 4; s++) begin
            wr(BRC_LEVEL_OFS, 8'h33);
            wr(BRC_FILTER_OFS, s[7:0]);
            low_supply <= 1'b1;
            wait_rst(800, n, nt);
            low_supply <= 1'b0;
            check({31'h0, nt >= want[s] - 1 && nt <= want[s] + 1}, 32'h1, "filter length");
            repeat (4) @(posedge core_clk);
            rd(BRC_LEVEL_OFS, 8'h33, "level kept after brownout");
            rd(BRC_CAUSE_OFS, 8'h04, "brownout event flag set");
            wr(BRC_CAUSE_OFS, 8'h00);
            rd(BRC_CAUSE_OFS, 8'h00, "brownout event flag cleared");
        end
    endtask
    // Excursions shorter than the filter time, with a release between them
    task automatic t_short_dips();
        int n;
        int nt;
        wr(BRC_FILTER_OFS, 8'h01);
        for (int k = 0; k < 2; k++) begin
            low_supply <= 1'b1;
            wait_rst(80, n, nt);
            low_supply <= 1'b0;
            check(n, 80, "short dip caused reset");
            repeat (8) @(posedge core_clk);
        end
        rd(BRC_CAUSE_OFS, 8'h00, "no flag after short dips");
    endtask
    task automatic t_bad_level();
        int n;
        int nt;
        wr(BRC_LEVEL_OFS, 8'h12);
        wait_rst(60, n, nt);
        check({31'h0, n >= 25 && n <= 32}, 32'h1, "bad level reset delay");
        repeat (2) @(posedge core_clk);
        rd(BRC_LEVEL_OFS, 8'h66, "level restored");
        wr(BRC_CAUSE_OFS, 8'h02);
        rd(BRC_CAUSE_OFS, 8'h02, "bad level flag held by write one");
        wr(BRC_CAUSE_OFS, 8'h00);
        rd(BRC_CAUSE_OFS, 8'h00, "bad level flag cleared");
    endtask
    task automatic t_wd_normal();
        int n;
        int nt;
        wr(BRC_LEVEL_OFS, 8'h55);
        wr(BRC_FILTER_OFS, 8'h02);
        wr(BRC_WDCTL_OFS, 8'h52);
        @(posedge core_clk);
        check({29'h0, wdt_period_sel}, 32'h2, "watchdog period select");
        pulse_expire();
        wait_rst(6, n, nt);
        check({31'h0, chip_rst}, 32'h1, "normal expiry reset");
        repeat (2) @(posedge core_clk);
        rd(BRC_STATUS_OFS, 8'h02, "expiry flag after normal expiry");
        rd(BRC_LEVEL_OFS, 8'h66, "level reloaded");
        rd(BRC_FILTER_OFS, 8'h01, "filter reloaded");
        rd(BRC_WDCTL_OFS, 8'h57, "watchdog ctrl reloaded");
    endtask
    // Expiry while asleep, with the supply low too: no chip reset at all
    task automatic t_wd_sleep();
        int seen_pc = 0;
        int seen_rst = 0;
        wr(BRC_LEVEL_OFS, 8'h55);
        sleep_mode <= 1'b1;
        low_supply <= 1'b1;
        pulse_expire();
        for (int i = 0; i < 300; i++) begin
            @(posedge core_clk);
            if (pc_sp_clr === 1'b1 && i < 4) seen_pc++;
            if (chip_rst === 1'b1) seen_rst++;
        end
        check(seen_pc, 1, "sleep expiry clears pc and sp once");
        check(seen_rst, 0, "no chip reset while asleep");
        low_supply <= 1'b0;
        sleep_mode <= 1'b0;
        rd(BRC_STATUS_OFS, 8'h03, "both flags after sleep expiry");
        rd(BRC_LEVEL_OFS, 8'h55, "level kept on sleep expiry");
    endtask
    // Brownout leaves the status flags; power-on clears them
    task automatic t_status_flags();
        int n;
        int nt;
        wr(BRC_FILTER_OFS, 8'h00);
        low_supply <= 1'b1;
        wait_rst(100, n, nt);
        low_supply <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(BRC_STATUS_OFS, 8'h03, "status kept on brownout");
        wr(BRC_CAUSE_OFS, 8'h00);
        wr(BRC_WDCTL_OFS, 8'h52);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rd(BRC_STATUS_OFS, 8'h00, "status cleared by power-on");
        rd(BRC_LEVEL_OFS, 8'h66, "level after power-on");
        check({29'h0, wdt_period_sel}, 32'h7, "watchdog restarted at power-on");
    endtask
    // Illegal enable code; it stays in place, so fix it straight after the reset
    task automatic t_wd_code();
        int n;
        int nt;
        wr(BRC_WDCTL_OFS, 8'h00);
        wait_rst(60, n, nt);
        check({31'h0, n >= 25 && n <= 32}, 32'h1, "watchdog code reset delay");
        wr(BRC_WDCTL_OFS, 8'h57);
        repeat (40) @(posedge core_clk);
        rd(BRC_CAUSE_OFS, 8'h01, "watchdog misuse flag set");
        wr(BRC_CAUSE_OFS, 8'h00);
        rd(BRC_CAUSE_OFS, 8'h00, "watchdog misuse flag cleared");
    endtask
    // ==============================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_power_on();
        t_level_decode();
        t_filter_lengths();
        t_short_dips();
        t_bad_level();
        t_wd_normal();
        t_wd_sleep();
        t_status_flags();
        t_wd_code();
        tally_and_finish();
    end
endmodule
